// ### verilog/lidc_pkg.sv
`default_nettype none
package lidc_pkg;
  // Geometry of the indication panel.
  localparam int N_LED  = 15;
  localparam int N_PAGE = 3;
  localparam int N_COL  = 3;
  localparam int N_CH   = N_LED * N_PAGE * N_COL;
  localparam int N_SRC  = 8;
  localparam int N_ST   = 5;

  // Colour slot positions inside one LED's group of three channels.
  localparam int COL_GREEN  = 0;
  localparam int COL_YELLOW = 1;
  localparam int COL_RED    = 2;

  // Register byte offsets.
  localparam logic [11:0] ADDR_ROUTE     = 12'h004;
  localparam logic [11:0] ADDR_CMD       = 12'h008;
  localparam logic [11:0] ADDR_STATUS    = 12'h00c;
  localparam logic [11:0] ADDR_MASK      = 12'h010;
  localparam logic [11:0] ADDR_STATE     = 12'h014;
  localparam logic [11:0] ADDR_MODE_BASE = 12'h100;

  // Command register bits.
  localparam int CMD_ACK_BIT = 0;
  localparam int CMD_RST_BIT = 1;

  // Status and mask bit positions.
  localparam int ST_START = 0;
  localparam int ST_TRIP  = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_ALARM = 3;
  localparam int ST_LINK  = 4;

  // State register bit positions.
  localparam int SR_READY = 0;
  localparam int SR_START = 1;
  localparam int SR_TRIP  = 2;
  localparam int SR_PAGE  = 3;
  localparam int SR_LINK  = 4;
  localparam int SR_FLASH = 5;
  localparam int SR_SLAT  = 6;
  localparam int SR_TLAT  = 7;
  localparam int SR_UNACK = 8;

  // Reset values.
  localparam logic [2*N_SRC-1:0] ROUTE_RST = 16'h0000;
  localparam logic [N_ST-1:0]    MASK_RST  = 5'h00;

  // Flash cadence.
  localparam int CLK_HZ            = 50_000_000;
  localparam int FLASH_HALF_MS     = 250;
  localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    ROUTE_OFF   = 2'b00,
    ROUTE_START = 2'b01,
    ROUTE_TRIP  = 2'b10
  } lidc_route_t;

  typedef enum logic [2:0] {
    SEQ_OFF       = 3'b000,
    SEQ_FOLLOW_S  = 3'b001,
    SEQ_FOLLOW_F  = 3'b010,
    SEQ_COLL_S    = 3'b011,
    SEQ_ACK_F_S   = 3'b100,
    SEQ_ACK_S_F   = 3'b101,
    SEQ_RESET_S   = 3'b110
  } lidc_seq_t;
endpackage
`default_nettype wire

// ### verilog/lidc_ind_channel.sv
`timescale 1ns/1ps
`default_nettype none
module lidc_ind_channel (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              act,
  input  wire logic              ack,
  input  wire logic              rst,
  input  wire logic              flash,
  input  wire lidc_pkg::lidc_seq_t mode,
  output logic                   lit,
  output logic                   unack
);
  typedef struct packed {
    logic act_prev;
    logic pend;
    logic lit;
  } lidc_ch_t;

  lidc_ch_t st_reg;
  lidc_ch_t st_next;
  logic     rise;

  always_comb begin
    st_next          = st_reg;
    rise             = act & ~st_reg.act_prev;
    st_next.act_prev = act;
    // A new activation edge wins over an acknowledge or reset in the same cycle.
    case (mode)
      lidc_pkg::SEQ_COLL_S, lidc_pkg::SEQ_ACK_F_S, lidc_pkg::SEQ_ACK_S_F: begin
        st_next.pend = rise | (st_reg.pend & ~(ack | rst));
      end
      lidc_pkg::SEQ_RESET_S: begin
        st_next.pend = rise | (st_reg.pend & ~rst);
      end
      default: begin
        st_next.pend = 1'b0;
      end
    endcase
    case (mode)
      lidc_pkg::SEQ_FOLLOW_S: st_next.lit = act;
      lidc_pkg::SEQ_FOLLOW_F: st_next.lit = act & flash;
      lidc_pkg::SEQ_COLL_S:   st_next.lit = act | st_next.pend;
      lidc_pkg::SEQ_ACK_F_S:  st_next.lit = st_next.pend ? flash : act;
      lidc_pkg::SEQ_ACK_S_F:  st_next.lit = st_next.pend | (act & flash);
      lidc_pkg::SEQ_RESET_S:  st_next.lit = act | st_next.pend;
      default:                st_next.lit = 1'b0;
    endcase
    if (srst) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign lit   = st_reg.lit;
  // Reset-latched indications wait for a reset, not an acknowledge.
  assign unack = st_reg.pend & (mode != lidc_pkg::SEQ_RESET_S);
endmodule
`default_nettype wire

// ### verilog/lidc_top.sv
// Overview of operation
// - Ready lamp steady in normal operation, flashing while self-supervision reports a fault.
// - Start lamp lights on any start and latches until a reset command.
// - Start lamp flashes during test-mode or protocol blocking, else steady state.
// - Trip lamp latches on trip until reset; flashes in configuration mode.
// - Each source is routed to nothing, start lamp or trip lamp by setting.
// - Fifteen three-colour alarm LEDs; each input drives one colour of one LED.
// - Alarm LED dark when inactive and nothing latched or unacknowledged.
// - Steady follow: lit exactly while activation is on.
// - Flashing follow: flashes exactly while activation is on.
// - Collecting latch: steady while active, then lit until acknowledged.
// - Flash then steady: flash until acknowledged, then steady while active.
// - Steady then flash: steady until acknowledged, then flash while active.
// - Reset latch: steady while active, then lit until reset.
// - Green link lamp follows cable link; yellow link lamp always off.
// - Across pages, red beats yellow and yellow beats green on one LED.
// - Three pages share the fifteen LEDs, each page with all three colour slots per LED.
// - Page button lamp lit if any alarm lit, blinking while any unacknowledged.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module lidc_top #(
  parameter int FLASH_HALF_CYCLES = lidc_pkg::FLASH_HALF_CYCLES,
  parameter int N_SRC             = lidc_pkg::N_SRC
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      internal_fault,
  input  wire logic [N_SRC-1:0]          prot_src,
  input  wire logic                      test_block,
  input  wire logic                      proto_block,
  input  wire logic                      config_mode,
  input  wire logic [lidc_pkg::N_CH-1:0] alarm_act,
  input  wire logic                      ack_pulse,
  input  wire logic                      reset_pulse,
  input  wire logic                      reset_bin,
  input  wire logic                      link_detect,
  output logic                           ready_led,
  output logic                           start_led,
  output logic                           trip_led,
  output logic [lidc_pkg::N_LED-1:0]     alarm_green,
  output logic [lidc_pkg::N_LED-1:0]     alarm_yellow,
  output logic [lidc_pkg::N_LED-1:0]     alarm_red,
  output logic                           page_led,
  output logic                           link_green,
  output logic                           link_yellow,
  output logic                           irq
);
  localparam int N_CH = lidc_pkg::N_CH;
  localparam int N_LED = lidc_pkg::N_LED;
  localparam int N_ST = lidc_pkg::N_ST;
  localparam int CW = $clog2(FLASH_HALF_CYCLES + 1);
  localparam logic [CW-1:0] FLASH_LAST = CW'(FLASH_HALF_CYCLES - 1);

  typedef struct packed {
    logic [N_CH*3-1:0]  mode;
    logic [2*N_SRC-1:0] route;
    logic [N_ST-1:0]    status;
    logic [N_ST-1:0]    mask;
    logic [N_ST-1:0]    ev_prev;
    logic               start_latch;
    logic               trip_latch;
    logic [CW-1:0]      flash_cnt;
    logic               flash_ph;
    logic               link_s1;
    logic               link_s2;
    logic               ready_led;
    logic               start_led;
    logic               trip_led;
    logic               page_led;
    logic               link_green;
    logic               link_yellow;
    logic               irq;
    logic [N_LED-1:0]   grn;
    logic [N_LED-1:0]   yel;
    logic [N_LED-1:0]   red;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } lidc_state_t;

  lidc_state_t      st_reg;
  lidc_state_t      st_next;
  logic [N_CH-1:0]  ch_lit;
  logic [N_CH-1:0]  ch_unack;
  logic             ack_all;
  logic             rst_all;
  logic             acc_wr;
  logic             acc_rd;
  logic             setup;
  logic             mode_hit;
  logic [11:0]      mode_off;
  logic [9:0]       mode_idx;

  // The access phase always completes in its first cycle.
  assign setup    = psel & ~penable;
  assign acc_wr   = psel & penable & st_reg.pready & pwrite;
  assign acc_rd   = psel & penable & st_reg.pready & ~pwrite;
  assign mode_off = paddr - lidc_pkg::ADDR_MODE_BASE;
  assign mode_idx = mode_off[11:2];
  assign mode_hit = (paddr >= lidc_pkg::ADDR_MODE_BASE) && (mode_off[1:0] == 2'b00)
                    && (int'(mode_idx) < N_CH);

  // Commands from the bus join the operator and binary-input pulses.
  assign ack_all = ack_pulse
                   | (acc_wr && paddr == lidc_pkg::ADDR_CMD && pwdata[lidc_pkg::CMD_ACK_BIT]);
  assign rst_all = reset_pulse | reset_bin
                   | (acc_wr && paddr == lidc_pkg::ADDR_CMD && pwdata[lidc_pkg::CMD_RST_BIT]);

  // One channel per page, LED and colour; each keeps its own latch.
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      lidc_ind_channel u_ch (
        .clk   (clk),
        .srst  (srst),
        .act   (alarm_act[g]),
        .ack   (ack_all),
        .rst   (rst_all),
        .flash (st_reg.flash_ph),
        .mode  (lidc_pkg::lidc_seq_t'(st_reg.mode[g*3 +: 3])),
        .lit   (ch_lit[g]),
        .unack (ch_unack[g])
      );
    end
  endgenerate

  always_comb begin
    logic            any_start;
    logic            any_trip;
    logic            any_lit;
    logic            any_unack;
    logic [N_LED-1:0] g_any;
    logic [N_LED-1:0] y_any;
    logic [N_LED-1:0] r_any;
    logic [N_ST-1:0] ev_now;
    logic [N_ST-1:0] ev_set;
    logic [31:0]     rd;
    logic            err;
    st_next   = st_reg;
    any_start = 1'b0;
    any_trip  = 1'b0;
    g_any     = '0;
    y_any     = '0;
    r_any     = '0;
    rd        = 32'h0000_0000;
    err       = 1'b0;
    any_lit   = 1'b0;
    any_unack = 1'b0;
    ev_now    = '0;
    ev_set    = '0;

    // Flash phase generator shared by every flashing output.
    if (st_reg.flash_cnt == FLASH_LAST) begin
      st_next.flash_cnt = '0;
      st_next.flash_ph  = ~st_reg.flash_ph;
    end else begin
      st_next.flash_cnt = st_reg.flash_cnt + CW'(1);
    end

    // Sources routed to neither lamp are ignored, so a spare input cannot latch a lamp.
    for (int i = 0; i < N_SRC; i++) begin
      if (prot_src[i] && st_reg.route[2*i +: 2] == lidc_pkg::ROUTE_START) begin
        any_start = 1'b1;
      end
      if (prot_src[i] && st_reg.route[2*i +: 2] == lidc_pkg::ROUTE_TRIP) begin
        any_trip = 1'b1;
      end
    end
    // A start or trip in the reset cycle keeps the lamp latched.
    st_next.start_latch = any_start | (st_reg.start_latch & ~rst_all);
    st_next.trip_latch  = any_trip | (st_reg.trip_latch & ~rst_all);

    st_next.ready_led = internal_fault ? st_reg.flash_ph : 1'b1;
    if (test_block | proto_block) begin
      st_next.start_led = st_reg.flash_ph;
    end else begin
      st_next.start_led = st_next.start_latch;
    end
    st_next.trip_led = config_mode ? st_reg.flash_ph : st_next.trip_latch;

    // Channel order is page, then LED, then colour.
    for (int p = 0; p < lidc_pkg::N_PAGE; p++) begin
      for (int l = 0; l < N_LED; l++) begin
        g_any[l] = g_any[l] | ch_lit[(p*N_LED + l)*3 + lidc_pkg::COL_GREEN];
        y_any[l] = y_any[l] | ch_lit[(p*N_LED + l)*3 + lidc_pkg::COL_YELLOW];
        r_any[l] = r_any[l] | ch_lit[(p*N_LED + l)*3 + lidc_pkg::COL_RED];
      end
    end
    st_next.red = r_any;
    st_next.yel = y_any & ~r_any;
    st_next.grn = g_any & ~y_any & ~r_any;

    // Blinking takes precedence over steady so an unseen alarm is never hidden.
    any_lit   = |ch_lit;
    any_unack = |ch_unack;
    st_next.page_led = any_unack ? st_reg.flash_ph : any_lit;

    // The first stage only feeds the second stage.
    st_next.link_s1    = link_detect;
    st_next.link_s2    = st_reg.link_s1;
    st_next.link_green = st_reg.link_s2;
    st_next.link_yellow = 1'b0;

    // Status events are edges, so a lasting condition raises its bit only once.
    ev_now = '0;
    ev_now[lidc_pkg::ST_START] = st_reg.start_latch;
    ev_now[lidc_pkg::ST_TRIP]  = st_reg.trip_latch;
    ev_now[lidc_pkg::ST_FAULT] = internal_fault;
    ev_now[lidc_pkg::ST_ALARM] = any_unack;
    ev_now[lidc_pkg::ST_LINK]  = st_reg.link_s2;
    ev_set = ev_now & ~st_reg.ev_prev;
    ev_set[lidc_pkg::ST_LINK] = st_reg.link_s2 ^ st_reg.ev_prev[lidc_pkg::ST_LINK];
    st_next.ev_prev = ev_now;

    // Read data is prepared during setup so the access phase needs no wait.
    case (paddr)
      lidc_pkg::ADDR_ROUTE:  rd[2*N_SRC-1:0] = st_reg.route;
      lidc_pkg::ADDR_CMD:    rd = 32'h0000_0000;
      lidc_pkg::ADDR_STATUS: rd[N_ST-1:0] = st_reg.status;
      lidc_pkg::ADDR_MASK:   rd[N_ST-1:0] = st_reg.mask;
      lidc_pkg::ADDR_STATE: begin
        rd[lidc_pkg::SR_READY] = st_reg.ready_led;
        rd[lidc_pkg::SR_START] = st_reg.start_led;
        rd[lidc_pkg::SR_TRIP]  = st_reg.trip_led;
        rd[lidc_pkg::SR_PAGE]  = st_reg.page_led;
        rd[lidc_pkg::SR_LINK]  = st_reg.link_green;
        rd[lidc_pkg::SR_FLASH] = st_reg.flash_ph;
        rd[lidc_pkg::SR_SLAT]  = st_reg.start_latch;
        rd[lidc_pkg::SR_TLAT]  = st_reg.trip_latch;
        rd[lidc_pkg::SR_UNACK] = any_unack;
      end
      default: begin
        if (mode_hit) begin
          rd[2:0] = st_reg.mode[int'(mode_idx)*3 +: 3];
        end else begin
          err = 1'b1;
        end
      end
    endcase
    st_next.pready  = setup;
    st_next.prdata  = (setup & ~pwrite) ? rd : 32'h0000_0000;
    st_next.pslverr = setup & err;

    // A write to an unmapped or read-only offset is dropped; only an unmapped offset gets the error response.
    if (acc_wr && !st_reg.pslverr) begin
      case (paddr)
        lidc_pkg::ADDR_ROUTE: st_next.route = pwdata[2*N_SRC-1:0];
        lidc_pkg::ADDR_MASK:  st_next.mask = pwdata[N_ST-1:0];
        default: begin
          if (mode_hit) begin
            st_next.mode[int'(mode_idx)*3 +: 3] = pwdata[2:0];
          end
        end
      endcase
    end

    // A read of the status register clears it, but a new event still sets its bit.
    if (acc_rd && paddr == lidc_pkg::ADDR_STATUS) begin
      st_next.status = ev_set;
    end else begin
      st_next.status = st_reg.status | ev_set;
    end
    st_next.irq = |(st_next.status & st_next.mask);

    // Reset overrides everything else, so a pulse during reset leaves no latch behind.
    if (srst) begin
      st_next       = '0;
      st_next.route = lidc_pkg::ROUTE_RST;
      st_next.mask  = lidc_pkg::MASK_RST;
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign prdata       = st_reg.prdata;
  assign pready       = st_reg.pready;
  assign pslverr      = st_reg.pslverr;
  assign ready_led    = st_reg.ready_led;
  assign start_led    = st_reg.start_led;
  assign trip_led     = st_reg.trip_led;
  assign alarm_green  = st_reg.grn;
  assign alarm_yellow = st_reg.yel;
  assign alarm_red    = st_reg.red;
  assign page_led     = st_reg.page_led;
  assign link_green   = st_reg.link_green;
  // The yellow link lamp has no function; a flop held at zero keeps every output registered.
  assign link_yellow  = st_reg.link_yellow;
  assign irq          = st_reg.irq;
endmodule
`default_nettype wire

// ### dv/lidc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lidc_checker #(
  parameter int FLASH_HALF_CYCLES = lidc_pkg::FLASH_HALF_CYCLES,
  parameter int N_SRC             = lidc_pkg::N_SRC
) (
  input wire logic                     clk,
  input wire logic                     srst,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [11:0]              paddr,
  input wire logic                     pready,
  input wire logic                     internal_fault,
  input wire logic [N_SRC-1:0]         prot_src,
  input wire logic                     test_block,
  input wire logic                     proto_block,
  input wire logic                     config_mode,
  input wire logic                     reset_pulse,
  input wire logic                     reset_bin,
  input wire logic                     link_detect,
  input wire logic                     ready_led,
  input wire logic                     start_led,
  input wire logic                     trip_led,
  input wire logic [lidc_pkg::N_LED-1:0] alarm_green,
  input wire logic [lidc_pkg::N_LED-1:0] alarm_yellow,
  input wire logic [lidc_pkg::N_LED-1:0] alarm_red,
  input wire logic                     link_green,
  input wire logic                     link_yellow
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic        cmd_wr;
  logic        ready_q;
  int unsigned run_q;
  assign cmd_wr = psel && penable && pwrite && (paddr == lidc_pkg::ADDR_CMD);
  // A stuck flash phase would leave the ready lamp frozen, so its stable runs are counted.
  always_ff @(posedge clk) begin
    ready_q <= ready_led;
    if (srst || !internal_fault || (ready_led != ready_q)) begin
      run_q <= 0;
    end else begin
      run_q <= run_q + 1;
    end
  end
  chk_link_off: assert property (!link_yellow)
    else $error("Yellow link lamp lit.");
  chk_link_up: assert property (link_detect [*4] |-> link_green)
    else $error("Green link lamp late.");
  chk_link_down: assert property (!link_detect [*4] |-> !link_green)
    else $error("Green link lamp stuck.");
  chk_ready_on: assert property (!srst && !internal_fault |=> ready_led)
    else $error("Ready lamp not steady.");
  chk_ready_blink: assert property (run_q <= FLASH_HALF_CYCLES + 2)
    else $error("Ready lamp not flashing.");
  chk_flash_phase: assert property ((internal_fault && test_block && config_mode) [*2] |->
    (ready_led == start_led) && (start_led == trip_led)) else $error("Lamps out of phase.");
  chk_start_hold: assert property ((!test_block && !proto_block) [*2] ##0
    (start_led && !reset_pulse && !reset_bin && !cmd_wr) |=> start_led)
    else $error("Start lamp lost latch.");
  chk_trip_hold: assert property ((!config_mode) [*2] ##0
    (trip_led && !reset_pulse && !reset_bin && !cmd_wr) |=> trip_led)
    else $error("Trip lamp lost latch.");
  chk_start_clear: assert property (reset_bin && prot_src == '0 && !test_block && !proto_block
    |=> !start_led) else $error("Start lamp not reset.");
  chk_trip_clear: assert property (reset_bin && prot_src == '0 && !config_mode |=> !trip_led)
    else $error("Trip lamp not reset.");
  chk_colour_one: assert property (((alarm_green & alarm_yellow) | (alarm_green & alarm_red)
    | (alarm_yellow & alarm_red)) == '0) else $error("Two colours on one LED.");
  chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("Bus answer timing wrong.");
  cover property ($rose(start_led));
  cover property ($rose(trip_led));
  cover property (alarm_red != '0);
  cover property (link_green);
endmodule
bind lidc_top lidc_checker #(.FLASH_HALF_CYCLES(FLASH_HALF_CYCLES), .N_SRC(N_SRC)) i_lidc_checker (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .internal_fault(internal_fault), .prot_src(prot_src),
  .test_block(test_block), .proto_block(proto_block), .config_mode(config_mode),
  .reset_pulse(reset_pulse), .reset_bin(reset_bin), .link_detect(link_detect),
  .ready_led(ready_led), .start_led(start_led), .trip_led(trip_led),
  .alarm_green(alarm_green), .alarm_yellow(alarm_yellow), .alarm_red(alarm_red),
  .link_green(link_green), .link_yellow(link_yellow));
`default_nettype wire

// ### dv/lidc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module lidc_far_model (
  input wire logic clk,
  output var logic ack_pulse,
  output var logic reset_pulse
);
  initial begin
    ack_pulse = 1'b0;
    reset_pulse = 1'b0;
  end
  // Commands last exactly one clock, so a held button never reaches the block.
  task automatic send(input logic rst);
    if (rst) begin
      reset_pulse <= 1'b1;
    end else begin
      ack_pulse <= 1'b1;
    end
    @(posedge clk);
    ack_pulse <= 1'b0;
    reset_pulse <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                      clk, srst, psel, penable, pwrite, pready, pslverr, er;
  logic                      internal_fault, test_block, proto_block, config_mode;
  logic                      ack_pulse, reset_pulse, reset_bin, link_detect, irq;
  logic                      ready_led, start_led, trip_led, page_led, link_green, link_yellow;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata, rd;
  logic [7:0]                prot_src;
  logic [lidc_pkg::N_CH-1:0] alarm_act;
  logic [14:0]               alarm_green, alarm_yellow, alarm_red;
  logic [3:0]                k;
  int                        err_count, check_count;
  // Expected look of LED 0 per mode: on, acked, released, re-pulsed, acked, reset.
  logic [23:0] mode_tab [0:7] = '{24'h000000, 24'h110000, 24'h220000, 24'h110100,
                                  24'h210200, 24'h120100, 24'h111110, 24'h000000};
  lidc_top #(.FLASH_HALF_CYCLES(4)) i_lidc_top (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_fault(internal_fault), .prot_src(prot_src),
    .test_block(test_block), .proto_block(proto_block), .config_mode(config_mode),
    .alarm_act(alarm_act), .ack_pulse(ack_pulse), .reset_pulse(reset_pulse),
    .reset_bin(reset_bin), .link_detect(link_detect), .ready_led(ready_led),
    .start_led(start_led), .trip_led(trip_led), .alarm_green(alarm_green),
    .alarm_yellow(alarm_yellow), .alarm_red(alarm_red), .page_led(page_led),
    .link_green(link_green), .link_yellow(link_yellow), .irq(irq));
  lidc_far_model i_lidc_far_model (.clk(clk), .ack_pulse(ack_pulse), .reset_pulse(reset_pulse));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps back-to-back calls from driving psel twice at once.
    @(posedge clk);
  endtask
  // Classifies a lamp as dark (0), steady (1) or flashing (2) over more than one period.
  task automatic look(input int s);
    logic hi, lo, v;
    hi = 1'b0;
    lo = 1'b0;
    tick(3);
    repeat (10) begin
      @(posedge clk);
      v = (s == 0) ? alarm_green[0] : (s == 1) ? ready_led : (s == 2) ? start_led : trip_led;
      hi |= (v === 1'b1);
      lo |= (v === 1'b0);
    end
    k = (hi && lo) ? 4'h2 : hi ? 4'h1 : 4'h0;
  endtask
  task automatic t_reset;
    apb(1'b0, lidc_pkg::ADDR_ROUTE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    chk(ready_led, 1'b1);
    $display("t_reset done");
  endtask
  task automatic t_lamps;
    apb(1'b1, lidc_pkg::ADDR_ROUTE, 32'h9);
    prot_src <= 8'h04;
    tick(1);
    prot_src <= 8'h01;
    tick(1);
    prot_src <= 8'h00;
    tick(3);
    chk({start_led, trip_led}, 2'b10);
    test_block <= 1'b1;
    look(2);
    chk(k, 4'h2);
    test_block <= 1'b0;
    proto_block <= 1'b1;
    look(2);
    chk(k, 4'h2);
    proto_block <= 1'b0;
    look(2);
    chk(k, 4'h1);
    i_lidc_far_model.send(1'b1);
    tick(2);
    chk(start_led, 1'b0);
    internal_fault <= 1'b1;
    look(1);
    chk(k, 4'h2);
    internal_fault <= 1'b0;
    apb(1'b1, lidc_pkg::ADDR_MASK, 32'h2);
    tick(2);
    chk(irq, 1'b0);
    prot_src <= 8'h02;
    tick(1);
    prot_src <= 8'h00;
    tick(4);
    chk({trip_led, irq}, 2'b11);
    apb(1'b0, lidc_pkg::ADDR_STATUS, 32'h0);
    chk(rd[1], 1'b1);
    tick(2);
    chk(irq, 1'b0);
    config_mode <= 1'b1;
    look(3);
    chk(k, 4'h2);
    {internal_fault, test_block} <= 2'b11;
    tick(3);
    chk({start_led, ready_led}, {2{trip_led}});
    {internal_fault, test_block} <= 2'b00;
    config_mode <= 1'b0;
    reset_bin <= 1'b1;
    tick(1);
    reset_bin <= 1'b0;
    tick(2);
    chk(trip_led, 1'b0);
    $display("t_lamps done");
  endtask
  task automatic t_link;
    link_detect <= 1'b1;
    tick(5);
    chk({link_green, link_yellow}, 2'b10);
    link_detect <= 1'b0;
    tick(5);
    chk(link_green, 1'b0);
    $display("t_link done");
  endtask
  task automatic t_modes;
    logic [23:0] e;
    for (int m = 0; m <= 7; m++) begin
      apb(1'b1, lidc_pkg::ADDR_MODE_BASE, 32'(m));
      e = mode_tab[m];
      alarm_act[0] <= 1'b1;
      look(0);
      chk(k, e[23:20]);
      i_lidc_far_model.send(1'b0);
      look(0);
      chk(k, e[19:16]);
      alarm_act[0] <= 1'b0;
      look(0);
      chk(k, e[15:12]);
      alarm_act[0] <= 1'b1;
      tick(1);
      alarm_act[0] <= 1'b0;
      look(0);
      chk(k, e[11:8]);
      if (m[0]) begin
        apb(1'b1, lidc_pkg::ADDR_CMD, 32'h1 << lidc_pkg::CMD_ACK_BIT);
      end else begin
        i_lidc_far_model.send(1'b0);
      end
      look(0);
      chk(k, e[7:4]);
      if (m[0]) begin
        apb(1'b1, lidc_pkg::ADDR_CMD, 32'h1 << lidc_pkg::CMD_RST_BIT);
      end else begin
        i_lidc_far_model.send(1'b1);
      end
      look(0);
      chk(k, e[3:0]);
    end
    $display("t_modes done");
  endtask
  task automatic t_priority;
    apb(1'b1, lidc_pkg::ADDR_MODE_BASE + 12'h024, 32'h1);
    apb(1'b1, lidc_pkg::ADDR_MODE_BASE + 12'h0e0, 32'h1);
    alarm_act[9] <= 1'b1;
    tick(4);
    chk({alarm_green[3], page_led}, 2'b11);
    alarm_act[56] <= 1'b1;
    tick(4);
    chk({alarm_red[3], alarm_yellow[3], alarm_green[3]}, 3'b100);
    alarm_act[9] <= 1'b0;
    alarm_act[56] <= 1'b0;
    tick(4);
    chk({alarm_red[3], page_led}, 2'b00);
    $display("t_priority done");
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata, prot_src, alarm_act} = '0;
    {internal_fault, test_block, proto_block, config_mode, reset_bin, link_detect} = '0;
    srst = 1'b1;
    err_count = 0;
    check_count = 0;
    tick(4);
    srst <= 1'b0;
    tick(2);
    t_reset;
    t_lamps;
    t_link;
    t_modes;
    t_priority;
    final_report;
  end
  initial begin
    #400000;
    err_count++;
    final_report;
  end
endmodule
`default_nettype wire
